// >>> fcvt_defs.svh
// Constants for the conversion and negate datapath
// Functional notes
// - Truncating float-to-int flags op, latency three
// - Flag-only ops never touch status-word flags
// - Truncating op ignores status-word rounding mode
// - Denormal source flushed to zero, flags it
// - Flag vector bits 6..0, upper bits zero
// - Guard LSB zero leaves destination unchanged
// - Conditional negate, latency two
// - Int-to-float uses status-word rounding, latency three
// - Conversion flags sticky until explicit status write
// - Flag update with writeback, ORed with others
// - False guard blocks destination and flag update
// - Int-to-float flags op, latency three
// - Bad operand for inf/NaN/range, imprecise when bits are lost
`ifndef FCVT_DEFS_SVH
`define FCVT_DEFS_SVH
// Operation codes
`define OPC_FIX_RZ_FLAGS 8'h81
`define OPC_COND_NEG 8'h4D
`define OPC_INT_TO_FLOAT 8'h14
`define OPC_INT_TO_FLOAT_FLAGS 8'h82
// Fixed latencies in cycles
`define LAT_FLOAT 3
`define LAT_MEDIA 2
// Register byte offsets
`define REG_PSW 4'h0
`define REG_IRQ_STAT 4'h4
`define REG_IRQ_MASK 4'h8
// Flag positions and layout
`define FLAG_W 7
`define FLG_IN_FLUSHED 5
`define FLG_BAD_OPERAND 4
`define PSW_RM_LSB 8
// Rounding-mode codes
`define RM_NEAREST 2'h0
`define RM_ZERO 2'h1
`define RM_POS 2'h2
`define RM_NEG 2'h3
`define PSW_RESET 32'h0000_0000
// Single-precision exponent landmarks
`define EXP_MAX 8'hFF
`define EXP_BIAS 8'h7F
`define EXP_EXACT 8'h96
`define EXP_INT_LIMIT 8'h9E
`endif

// >>> fcvt_issue_model.sv
// Issue pipeline and register file model facing the datapath
`timescale 1ns/100ps
module fcvt_issue_model #(
  parameter int DEST_W = 7 // Register-file index width
) (
  input wire logic clk,
  input wire logic rst,
  output fcvt_pkg::issue_t issue,
  output logic [DEST_W-1:0] issueDest,
  input wire fcvt_pkg::wb_t floatWb,
  input wire logic [DEST_W-1:0] floatWbDest,
  input wire fcvt_pkg::wb_t mediaWb,
  input wire logic [DEST_W-1:0] mediaWbDest
);
  import fcvt_pkg::*;
  logic [31:0] regFile [2**DEST_W]; // Architectural registers

  // Idle issue slot until the first request
  initial begin
    issue = '0;
    issueDest = '0;
  end

  // Writebacks land only when a unit pulses valid
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < 2**DEST_W; k++) regFile[k] <= '0;
    end else begin
      if (floatWb.valid) regFile[floatWbDest] <= floatWb.data;
      if (mediaWb.valid) regFile[mediaWbDest] <= mediaWb.data;
    end
  end

  // One-cycle issue; operands are inverted afterwards so stale values never match
  task automatic send(input op_t op, input logic gp, input logic [31:0] g, s1, s2,
                      input logic [DEST_W-1:0] d);
    @(posedge clk);
    issue <= '{valid: 1'b1, op: op, guardPresent: gp, guard: g, src1: s1, src2: s2};
    issueDest <= d;
    @(posedge clk);
    issue <= '{valid: 1'b0, op: op, guardPresent: gp, guard: ~g, src1: ~s1, src2: ~s2};
    issueDest <= ~d;
  endtask : send
endmodule : fcvt_issue_model

// >>> fcvt_pkg.sv
// Types shared by the conversion and negate datapath
package fcvt_pkg;
  `include "fcvt_defs.svh"
  typedef enum logic [7:0] {
    OP_FIX_RZ_FLAGS = `OPC_FIX_RZ_FLAGS,
    OP_COND_NEG = `OPC_COND_NEG,
    OP_INT_TO_FLOAT = `OPC_INT_TO_FLOAT,
    OP_INT_TO_FLOAT_FLAGS = `OPC_INT_TO_FLOAT_FLAGS
  } op_t;
  typedef struct packed {
    logic outFlushed; // Result flushed to zero
    logic inFlushed; // Denormal source replaced by zero
    logic badOperand; // Infinity, NaN or out of range
    logic tooLarge; // Result overflowed
    logic tooSmall; // Result underflowed
    logic imprecise; // Bits lost in the conversion
    logic zeroDivisor; // Division by zero
  } flags_t;
  typedef struct packed {
    logic valid;
    op_t op;
    logic guardPresent;
    logic [31:0] guard;
    logic [31:0] src1;
    logic [31:0] src2;
  } issue_t;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } wb_t;
  typedef struct packed {
    logic [31:0] value;
    flags_t flags;
  } conv_t;
  typedef struct packed {
    logic valid;
    logic toPsw;
    logic [31:0] data;
    flags_t flags;
  } pipe_t;
endpackage : fcvt_pkg

// >>> int_float_convert_and_negate_unit.sv
// Float/int conversion, flag and conditional negate datapath
`timescale 1ns/100ps
module int_float_convert_and_negate_unit #(
  parameter int DEST_W = 7 // Register-file index width
) (
  input wire logic clk,
  input wire logic rst,
  input wire fcvt_pkg::issue_t issue,
  input wire logic [DEST_W-1:0] issueDest,
  input wire fcvt_pkg::flags_t otherFlags,
  input wire logic otherFlagsValid,
  output fcvt_pkg::wb_t floatWb,
  output logic [DEST_W-1:0] floatWbDest,
  output fcvt_pkg::wb_t mediaWb,
  output logic [DEST_W-1:0] mediaWbDest,
  output logic [31:0] statusWord,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  output logic irq
);
  import fcvt_pkg::*;
  `include "fcvt_defs.svh"

  // Refuse a destination index that cannot address anything
  if (DEST_W < 1) begin : g_chk
    $error("DEST_W must be at least one");
  end

  // Flags a truncating float-to-int conversion would raise
  function automatic flags_t fixFlags(input logic [31:0] f);
    logic [7:0] e;
    logic [22:0] m;
    logic [22:0] lowMask;
    flags_t r;
    e = f[30:23];
    m = f[22:0];
    r = '0;
    lowMask = '0;
    if (e == 8'h00) begin
      // Denormal is flushed to zero, which converts exactly
      r.inFlushed = (m != '0);
    end else if (e == `EXP_MAX) begin
      r.badOperand = 1'b1;
    end else if (e >= `EXP_INT_LIMIT) begin
      // Only -2^31 itself fits at the limit exponent
      r.badOperand = !(f[31] && e == `EXP_INT_LIMIT && m == '0);
    end else if (e < `EXP_BIAS) begin
      r.imprecise = 1'b1;
    end else if (e < `EXP_EXACT) begin
      // Chop toward zero; rounding mode plays no part
      lowMask = 23'h7FFFFF >> (e - `EXP_BIAS);
      r.imprecise = |(m & lowMask);
    end
    return r;
  endfunction : fixFlags

  // Signed int to single precision under a rounding mode
  function automatic conv_t toFloat(input logic [31:0] v, input logic [1:0] rm);
    logic [31:0] mag;
    logic [31:0] norm;
    logic [4:0] lead;
    logic [24:0] mant;
    logic [7:0] expo;
    logic grd;
    logic stk;
    logic inc;
    conv_t r;
    r = '0;
    mag = v[31] ? -v : v;
    lead = '0;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        lead = 5'(i);
      end
    end
    norm = mag << (5'd31 - lead);
    grd = norm[7];
    stk = |norm[6:0];
    unique case (rm)
      `RM_NEAREST: inc = grd && (stk || norm[8]);
      `RM_ZERO: inc = 1'b0;
      `RM_POS: inc = (grd || stk) && !v[31];
      `RM_NEG: inc = (grd || stk) && v[31];
    endcase
    mant = {1'b0, norm[31:8]} + {24'h000000, inc};
    expo = `EXP_BIAS + {3'h0, lead} + {7'h00, mant[24]};
    if (mag != '0) begin
      r.value = {v[31], expo, mant[24] ? mant[23:1] : mant[22:0]};
      r.flags.imprecise = grd || stk;
    end
    return r;
  endfunction : toFloat

  // Merge a bus write into a register under byte enables
  function automatic logic [31:0] byteMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : byteMerge

  logic guardOk; // Guard absent, or its LSB set
  logic floatIssue; // Float op accepted into the pipe
  logic mediaIssue; // Negate accepted into the pipe
  pipe_t fStage; // Float result computed at issue
  conv_t cvt; // Int-to-float result and flags
  pipe_t fPipe_q [`LAT_FLOAT]; // Float pipe stages
  logic [DEST_W-1:0] fDest_q [`LAT_FLOAT];
  pipe_t mPipe_q [`LAT_MEDIA]; // Media pipe stages
  logic [DEST_W-1:0] mDest_q [`LAT_MEDIA];
  logic [`FLAG_W-1:0] pswFlags_q; // Sticky exception flags
  logic [1:0] rm_q; // Rounding mode field
  logic [`FLAG_W-1:0] hwSet; // Flags raised this edge
  logic [`FLAG_W-1:0] irqStat_q; // Flag-raised events
  logic [`FLAG_W-1:0] irqMask_q; // Interrupt enables
  logic busReq; // Read or write on the bus
  logic ack_q; // Second cycle of a bus access
  logic pswWr; // Status word written this edge
  logic [31:0] pswWord; // Status word as software sees it
  logic [31:0] pswNew; // Status word after byte merge

  // Issue decode: a false guard drops the op entirely
  always_comb begin
    guardOk = !issue.guardPresent || issue.guard[0];
    floatIssue = issue.valid && guardOk &&
                 (issue.op == OP_FIX_RZ_FLAGS || issue.op == OP_INT_TO_FLOAT ||
                  issue.op == OP_INT_TO_FLOAT_FLAGS);
    mediaIssue = issue.valid && guardOk && issue.op == OP_COND_NEG;
  end

  // First float stage: compute now, carry the result along
  always_comb begin
    cvt = toFloat(issue.src1, rm_q);
    fStage = '0;
    fStage.valid = floatIssue;
    if (issue.op == OP_FIX_RZ_FLAGS) begin
      // Flag vector only, upper bits forced to zero
      fStage.data = {25'h0000000, fixFlags(issue.src1)};
    end else if (issue.op == OP_INT_TO_FLOAT_FLAGS) begin
      fStage.data = {25'h0000000, cvt.flags};
    end else begin
      // Only the real conversion feeds the status word
      fStage.data = cvt.value;
      fStage.flags = cvt.flags;
      fStage.toPsw = 1'b1;
    end
  end

  // Float pipe: fixed three-cycle latency
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int s = 0; s < `LAT_FLOAT; s++) begin
        fPipe_q[s] <= '0;
        fDest_q[s] <= '0;
      end
    end else begin
      fPipe_q[0] <= fStage;
      fDest_q[0] <= issueDest;
      for (int s = 1; s < `LAT_FLOAT; s++) begin
        fPipe_q[s] <= fPipe_q[s-1];
        fDest_q[s] <= fDest_q[s-1];
      end
    end
  end

  // Media pipe: negate when the first source is nonzero
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int s = 0; s < `LAT_MEDIA; s++) begin
        mPipe_q[s] <= '0;
        mDest_q[s] <= '0;
      end
    end else begin
      mPipe_q[0] <= '0;
      mPipe_q[0].valid <= mediaIssue;
      mPipe_q[0].data <= (issue.src1 != '0) ? -issue.src2 : issue.src2;
      mDest_q[0] <= issueDest;
      for (int s = 1; s < `LAT_MEDIA; s++) begin
        mPipe_q[s] <= mPipe_q[s-1];
        mDest_q[s] <= mDest_q[s-1];
      end
    end
  end

  // Writeback ports come straight from the last stages
  always_comb begin
    floatWb.valid = fPipe_q[`LAT_FLOAT-1].valid;
    floatWb.data = fPipe_q[`LAT_FLOAT-1].data;
    floatWbDest = fDest_q[`LAT_FLOAT-1];
    mediaWb.valid = mPipe_q[`LAT_MEDIA-1].valid;
    mediaWb.data = mPipe_q[`LAT_MEDIA-1].data;
    mediaWbDest = mDest_q[`LAT_MEDIA-1];
  end

  // Flags landing at the edge that loads the writeback stage
  always_comb begin
    hwSet = '0;
    if (fPipe_q[`LAT_FLOAT-2].valid && fPipe_q[`LAT_FLOAT-2].toPsw) begin
      hwSet = hwSet | fPipe_q[`LAT_FLOAT-2].flags;
    end
    if (otherFlagsValid) begin
      hwSet = hwSet | otherFlags;
    end
  end

  // Bus: one wait cycle, then the access completes
  always_comb begin
    busReq = avsRead || avsWrite;
    avsWaitRequest = busReq && !ack_q;
    pswWr = avsWrite && ack_q && avsAddress == `REG_PSW;
    pswWord = '0;
    pswWord[`FLAG_W-1:0] = pswFlags_q;
    pswWord[`PSW_RM_LSB +: 2] = rm_q;
    pswNew = byteMerge(pswWord, avsWriteData, avsByteEnable);
    statusWord = pswWord;
    irq = |(irqStat_q & irqMask_q);
  end

  // Bus handshake state
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= busReq && !ack_q;
    end
  end

  // Read data captured in the wait cycle; unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      avsReadData <= '0;
    end else if (avsRead && !ack_q) begin
      unique case (avsAddress)
        `REG_PSW: avsReadData <= pswWord;
        `REG_IRQ_STAT: avsReadData <= {25'h0000000, irqStat_q};
        `REG_IRQ_MASK: avsReadData <= {25'h0000000, irqMask_q};
        default: avsReadData <= '0;
      endcase
    end
  end

  // Status word: sticky flags; a raised flag beats a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pswFlags_q <= `FLAG_W'(`PSW_RESET);
      rm_q <= 2'h0;
    end else begin
      if (pswWr) begin
        pswFlags_q <= pswNew[`FLAG_W-1:0] | hwSet;
        rm_q <= pswNew[`PSW_RM_LSB +: 2];
      end else begin
        pswFlags_q <= pswFlags_q | hwSet;
      end
    end
  end

  // Interrupt status is write-one-to-clear; set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_q <= '0;
    end else if (avsWrite && ack_q && avsAddress == `REG_IRQ_STAT) begin
      irqStat_q <= (irqStat_q & ~avsWriteData[`FLAG_W-1:0]) | hwSet;
    end else begin
      irqStat_q <= irqStat_q | hwSet;
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk) begin
    if (rst) begin
      irqMask_q <= '0;
    end else if (avsWrite && ack_q && avsAddress == `REG_IRQ_MASK && avsByteEnable[0]) begin
      irqMask_q <= avsWriteData[`FLAG_W-1:0];
    end
  end

  // Truncating flag op answers three cycles on, upper bits zero
  property p_fixLatency;
    @(posedge clk) disable iff (rst)
    floatIssue && issue.op == OP_FIX_RZ_FLAGS |->
      ##3 floatWb.valid && floatWb.data[31:`FLAG_W] == '0;
  endproperty
  a_fixLatency: assert property (p_fixLatency) else $error("fix flags latency");

  // Denormal source gives only the input-flushed flag
  property p_fixDenorm;
    @(posedge clk) disable iff (rst)
    floatIssue && issue.op == OP_FIX_RZ_FLAGS && issue.src1[30:23] == 8'h00 &&
      issue.src1[22:0] != '0 |-> ##3 floatWb.data == (32'h0000_0001 << `FLG_IN_FLUSHED);
  endproperty
  a_fixDenorm: assert property (p_fixDenorm) else $error("denormal not flushed");

  // Infinity or NaN reports a bad operand
  property p_fixInf;
    @(posedge clk) disable iff (rst)
    floatIssue && issue.op == OP_FIX_RZ_FLAGS && issue.src1[30:23] == `EXP_MAX |->
      ##3 floatWb.data[`FLG_BAD_OPERAND];
  endproperty
  a_fixInf: assert property (p_fixInf) else $error("inf or NaN not bad");

  // Negate result two cycles after issue
  property p_negate;
    @(posedge clk) disable iff (rst)
    mediaIssue |-> ##2 mediaWb.valid && mediaWb.data ==
      (($past(issue.src1, 2) != '0) ? -$past(issue.src2, 2) : $past(issue.src2, 2));
  endproperty
  a_negate: assert property (p_negate) else $error("negate wrong");

  // A false guard produces no writeback at either latency
  property p_guardOff;
    @(posedge clk) disable iff (rst)
    issue.valid && issue.guardPresent && !issue.guard[0] |->
      ##2 !mediaWb.valid ##1 !floatWb.valid;
  endproperty
  a_guardOff: assert property (p_guardOff) else $error("guarded op wrote");

  // Zero converts to zero with no flags
  property p_intZero;
    @(posedge clk) disable iff (rst)
    floatIssue && issue.op == OP_INT_TO_FLOAT && issue.src1 == '0 |->
      ##3 floatWb.valid && floatWb.data == '0;
  endproperty
  a_intZero: assert property (p_intZero) else $error("zero convert wrong");

  // Flag-only ops leave the status flags alone
  property p_flagOnlyKeep;
    @(posedge clk) disable iff (rst)
    fPipe_q[1].valid && !fPipe_q[1].toPsw && !otherFlagsValid && !pswWr |=>
      $stable(pswFlags_q);
  endproperty
  a_flagOnlyKeep: assert property (p_flagOnlyKeep) else $error("flag op hit status");

  // Only an explicit status write may drop a flag
  property p_sticky;
    @(posedge clk) disable iff (rst)
    !pswWr |=> (pswFlags_q & $past(pswFlags_q)) == $past(pswFlags_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by compute");

  // Conversion flags visible with its writeback
  property p_sameCycle;
    @(posedge clk) disable iff (rst)
    fPipe_q[2].valid && fPipe_q[2].toPsw |->
      (pswFlags_q & fPipe_q[2].flags) == fPipe_q[2].flags;
  endproperty
  a_sameCycle: assert property (p_sameCycle) else $error("flags late");

  // Other units' flags are ORed in
  property p_orMerge;
    @(posedge clk) disable iff (rst)
    otherFlagsValid |=> (pswFlags_q & $past(otherFlags)) == $past(otherFlags);
  endproperty
  a_orMerge: assert property (p_orMerge) else $error("other flags lost");
endmodule : int_float_convert_and_negate_unit

// >>> tb_int_float_convert_and_negate_unit.sv
// Self-checking bench for the conversion and negate datapath
`timescale 1ns/100ps
module tb_int_float_convert_and_negate_unit;
  import fcvt_pkg::*;
  logic clk, rst, otherFlagsValid, avsRead, avsWrite, avsWaitRequest, irq;
  flags_t otherFlags;
  issue_t issue;
  wb_t floatWb, mediaWb;
  logic [6:0] issueDest, floatWbDest, mediaWbDest;
  logic [31:0] statusWord, avsWriteData, avsReadData, pswExp, rd, r;
  logic [3:0] avsAddress, avsByteEnable;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  op_t ops [4] = '{OP_FIX_RZ_FLAGS, OP_COND_NEG, OP_INT_TO_FLOAT, OP_INT_TO_FLOAT_FLAGS};
  // Corner floats: exact, fraction, huge, inf, denormal, NaNs, -2^31, 2^31
  logic [31:0] fx [11] = '{32'h40400000, 32'h40247AE1, 32'hFF4FFFFF, 32'h7F800000,
    32'hBFC147AE, 32'h00400000, 32'hFFFFFFFF, 32'hFFBFFFFF, 32'hCF000000, 32'h4F000000,
    32'h3F000000};
  // Corner integers, including ties and carries out of the mantissa
  logic [31:0] ix [8] = '{32'h3, 32'hFFFFFFFF, 32'hFFFFFFFD, 32'h7FFFFFFF, 32'h80000000,
    32'h7FFFFFF1, 32'h01000001, 32'hFE000003};

  int_float_convert_and_negate_unit dut_u (.clk, .rst, .issue, .issueDest, .otherFlags,
    .otherFlagsValid, .floatWb, .floatWbDest, .mediaWb, .mediaWbDest, .statusWord,
    .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData,
    .avsWaitRequest, .irq);
  fcvt_issue_model model_u (.clk, .rst, .issue, .issueDest, .floatWb, .floatWbDest,
    .mediaWb, .mediaWbDest);

  // 250 MHz clock
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // Hang guard, far above the roughly 1100 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  // Flags of a truncating float-to-int conversion
  function automatic logic [31:0] fix_flags(input logic [31:0] f);
    logic [7:0] e;
    logic [22:0] m;
    int sh;
    e = f[30:23];
    m = f[22:0];
    if (e == 8'h00) return (m != 0) ? 32'h20 : 32'h0;
    if (e == 8'hFF || (e >= 8'h9E && f != 32'hCF000000)) return 32'h10;
    if (e < 8'h7F) return 32'h2;
    sh = 150 - int'(e);
    if (sh > 0 && (m & ((23'h1 << sh) - 23'h1)) != 0) return 32'h2;
    return 32'h0;
  endfunction : fix_flags

  // Int to single float: {inexact, value} under a rounding mode
  function automatic logic [32:0] to_float(input logic [31:0] i, input logic [1:0] rm);
    logic s, up;
    logic [31:0] mag, keep, rem, half;
    int p, sh;
    if (i == 0) return 33'h0;
    s = i[31];
    mag = s ? -i : i;
    p = 31;
    while (!mag[p]) p--;
    if (p <= 23) return {1'b0, s, 8'(p + 127), 23'(mag << (23 - p))};
    sh = p - 23;
    keep = mag >> sh;
    rem = mag & ((32'h1 << sh) - 1);
    half = 32'h1 << (sh - 1);
    case (rm)
      2'h0: up = rem > half || (rem == half && keep[0]);
      2'h1: up = 1'b0;
      2'h2: up = rem != 0 && !s;
      default: up = rem != 0 && s;
    endcase
    keep = keep + up;
    if (keep[24]) begin
      keep = keep >> 1;
      p++;
    end
    return {rem != 0, s, 8'(p + 127), keep[22:0]};
  endfunction : to_float

  // Avalon-MM access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= wd;
    avsByteEnable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsRead <= 0;
    avsWrite <= 0;
    check(n == 2, "bus wait state");
  endtask : bus

  // Full status write: rounding mode set, flags cleared
  task automatic set_rm(input logic [1:0] m);
    bus(1, 4'h0, {22'h0, m, 8'h0}, 4'hF, rd);
    pswExp = {22'h0, m, 8'h0};
  endtask : set_rm

  // Issues one op, other-unit flags landing with the float writeback
  task automatic run_op(input op_t op, input logic gp, input logic [31:0] g, s1, s2,
                        input logic [6:0] of);
    logic take, isF;
    logic [31:0] expD, old;
    logic [32:0] cv;
    logic [6:0] d;
    d = 7'($urandom);
    old = model_u.regFile[d];
    take = !gp || g[0];
    isF = op != OP_COND_NEG;
    cv = to_float(s1, pswExp[9:8]);
    case (op)
      OP_FIX_RZ_FLAGS: expD = fix_flags(s1);
      OP_COND_NEG: expD = (s1 == 0) ? s2 : -s2;
      OP_INT_TO_FLOAT: expD = cv[31:0];
      default: expD = {30'h0, cv[32], 1'b0};
    endcase
    model_u.send(op, gp, g, s1, s2, d);
    @(posedge clk);
    otherFlags <= flags_t'(of);
    otherFlagsValid <= |of;
    #1;
    check(mediaWb.valid === (take && !isF), "negate timing");
    if (take && !isF) check(mediaWb.data === expD, "negate data");
    check(floatWb.valid === 1'b0 && statusWord === pswExp, "early float");
    @(posedge clk);
    otherFlags <= '0;
    otherFlagsValid <= 0;
    if (take && op == OP_INT_TO_FLOAT) pswExp[1] |= cv[32];
    pswExp[6:0] |= of;
    #1;
    check(floatWb.valid === (take && isF) && !mediaWb.valid, "float timing");
    if (take && isF) check(floatWb.data === expD, "float data");
    check(statusWord === pswExp, "status flags");
    @(posedge clk);
    #1;
    check(model_u.regFile[d] === (take ? expD : old), "destination");
  endtask : run_op

  initial begin
    {rst, otherFlagsValid, avsRead, avsWrite} = 4'h8;
    {otherFlags, avsAddress, avsWriteData, avsByteEnable, pswExp} = '0;
    void'($urandom(1956));
    repeat (20) @(posedge clk);
    rst <= 0;
    // Reset values, the last address unmapped
    for (int a = 0; a < 16; a += 4) begin
      bus(0, 4'(a), 0, 4'hF, rd);
      check(rd === 32'h0, "reset value");
    end
    bus(1, 4'hC, 32'hFFFFFFFF, 4'hF, rd);
    bus(0, 4'hC, 0, 4'hF, rd);
    check(rd === 32'h0, "unmapped");
    $display("test registers done");
    // Truncating flags must not follow the rounding mode
    for (int m = 0; m < 4; m++) begin
      set_rm(2'(m));
      foreach (fx[k]) run_op(OP_FIX_RZ_FLAGS, 0, 0, fx[k], 0, 0);
      run_op(OP_FIX_RZ_FLAGS, 1, 32'hFFFFFFFE, fx[2], 0, 0);
    end
    $display("test truncating flags done");
    // Converting op and its flag-only twin under every mode
    for (int m = 0; m < 4; m++) begin
      set_rm(2'(m));
      foreach (ix[k]) begin
        run_op(OP_INT_TO_FLOAT, 0, 0, ix[k], 0, 0);
        run_op(OP_INT_TO_FLOAT_FLAGS, 1, 1, ix[k], 0, 0);
      end
    end
    $display("test int to float done");
    run_op(OP_COND_NEG, 0, 0, 0, 1, 0);
    run_op(OP_COND_NEG, 1, 1, 32'hFFFF0000, 32'hABC, 0);
    run_op(OP_COND_NEG, 1, 0, 32'hFFFF0000, 32'hABC, 0);
    run_op(OP_COND_NEG, 0, 0, 1, 32'h80000000, 0);
    $display("test negate done");
    // Sticky flags, simultaneous OR, false guard, byte-lane write
    set_rm(0);
    run_op(OP_INT_TO_FLOAT, 0, 0, ix[3], 0, 7'h01);
    run_op(OP_INT_TO_FLOAT, 0, 0, 3, 0, 0);
    bus(1, 4'h0, 32'h300, 4'h2, rd);
    pswExp[9:8] = 2'h3;
    #1;
    check(statusWord === pswExp, "byte lane write");
    set_rm(0);
    run_op(OP_INT_TO_FLOAT, 1, 32'h2, ix[3], 0, 0);
    $display("test sticky flags done");
    // Interrupt raised, masked, unmasked and cleared
    bus(1, 4'h4, 32'h7F, 4'hF, rd);
    bus(1, 4'h8, 32'h2, 4'hF, rd);
    run_op(OP_INT_TO_FLOAT, 0, 0, ix[3], 0, 0);
    check(irq === 1'b1, "irq raise");
    bus(0, 4'h4, 0, 4'hF, rd);
    check(rd === 32'h2, "irq status");
    bus(1, 4'h8, 32'h0, 4'hF, rd);
    #1;
    check(irq === 1'b0, "irq mask");
    bus(1, 4'h8, 32'h2, 4'hF, rd);
    #1;
    check(irq === 1'b1, "irq unmask");
    bus(1, 4'h4, 32'h2, 4'hF, rd);
    #1;
    check(irq === 1'b0, "irq clear");
    $display("test interrupt done");
    // Random ops, floats biased toward the integer range
    for (int n = 0; n < 80; n++) begin
      if (n % 16 == 0) set_rm(2'($urandom));
      r = $urandom;
      if (r[31]) r[30:23] = 8'h78 + 8'(r[4:0]);
      run_op(ops[$urandom % 4], 1'($urandom), $urandom, r, $urandom, 7'($urandom));
    end
    $display("test random done");
    end_of_test();
  end
endmodule : tb_int_float_convert_and_negate_unit
